// File: logic/ssn_pkg.sv
/*
 * ssn_pkg: offsets, field positions, reset values and timing for the sensor
 * status / non-volatile window register bank.
 * assumes: 100 MHz sys_clk; a word-wide register access port in front.
 */
package ssn_pkg;
    // ----------------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------------
    localparam logic [15:0] OFS_WEAK_CFG = 16'h000F;
    localparam logic [15:0] OFS_NVM_ADDR = 16'h0030;
    localparam logic [15:0] OFS_NVM_DATA = 16'h0031;
    localparam logic [15:0] OFS_STATUS = 16'h0107;
    localparam logic [15:0] OFS_CHECKSUM = 16'h0108;
    // ----------------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------------
    localparam int BIT_READY = 15;
    localparam int BIT_WEAK = 14;
    localparam int BIT_ANGLE_OVF = 13;
    localparam int BIT_SCALE_OVF = 12;
    localparam int BIT_TGAIN_OVF = 11;
    localparam int BIT_RANGE_WARN = 10;
    localparam int BIT_HIST_WARN = 9;
    localparam int BIT_FAULT = 8;
    localparam int BIT_ORIENT = 1;
    localparam int BIT_WR_DONE = 0;
    // ----------------------------------------------------------------------
    // weak-field config fields and reset values
    // ----------------------------------------------------------------------
    localparam int THR_LSB = 0;
    localparam int THR_W = 8;
    localparam int HYST_LSB = 8;
    localparam int HYST_W = 3;
    localparam int THR_SCALE_SHIFT = 6;
    localparam logic [15:0] WEAK_CFG_RST = 16'h0103;
    localparam logic [15:0] WEAK_CFG_MASK = 16'h07FF;
    localparam logic [15:0] NVM_ADDR_RST = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // ----------------------------------------------------------------------
    // memory and timing
    // ----------------------------------------------------------------------
    localparam int NVM_AW = 6;
    localparam int NVM_DEPTH = 64;
    localparam int CLK_MHZ = 100;
    localparam int NVM_WRITE_MS = 20;
    localparam int NVM_WRITE_CYC = NVM_WRITE_MS * 1000 * CLK_MHZ;

    typedef struct packed {
        logic angle_fix_overflow;
        logic scale_overflow;
        logic temp_gain_overflow;
        logic converter_range_warning;
        logic converter_histogram_warning;
        logic field_orientation;
    } ssn_flags_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ssn_req_t;

    typedef enum logic [1:0] {
        SSN_IDLE = 2'b01,
        SSN_PROG = 2'b10
    } ssn_nvm_state_t;
endpackage : ssn_pkg

// File: logic/ssn_regs.sv
/*
 * ssn_regs: status, checksum, weak-field config and non-volatile window
 * registers of the position sensor, reached through a word access port.
 * assumes: the serial front end delivers one-cycle rd/wr strobes on sys_clk;
 * the measurement pipeline supplies results, flags and a finish pulse;
 * flags and checksum are levels held steady by that pipeline;
 * memory words come up undefined until the host writes them;
 * the write timer default gives 20 ms at 100 MHz, benches shorten it.
 */
// How it works
// - data window reads/writes the memory word at the address register's location.
// - finish pulse sets ready after results are latched into result registers.
// - ready is 0 while computing or after reset; equals ready pin.
// - weak-field flag set when field magnitude is too low.
// - weak-field threshold comes from config register threshold field.
// - bit 13 angle-fix overflow, bit 12 scale overflow.
// - bit 11 reports temperature gain correction overflow.
// - bit 10 converter range warning, bit 9 histogram warning.
// - bit 8 ORs range, histogram, scale and gain overflow only.
// - bit 1 reports the field orientation.
// - bit 0 is 0 during a memory write, 1 when done.
// - read-only 16-bit checksum register for host verification.
// - memory write lasts 20 ms; host waits for write-done first.
// - threshold equals programmed 8-bit value times 64.
// - flag sets below threshold, clears above threshold plus hysteresis.
`timescale 1ns/100ps
module ssn_regs #(
    parameter int WRITE_CYC = ssn_pkg::NVM_WRITE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register access
    input wire ssn_pkg::ssn_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    // measurement pipeline
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic [15:0] magnitude,
    input wire ssn_pkg::ssn_flags_t flags,
    input wire logic [15:0] checksum,
    // pins
    output logic ready_pin
);
    // ----------------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------------
    // two stages so release never meets the state flops mid-edge
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------------
    // status and checksum get no write select, so writes there fall away
    logic wr_cfg;
    logic wr_addr;
    logic wr_data;

    assign wr_cfg = req.wr && (req.addr == ssn_pkg::OFS_WEAK_CFG);
    assign wr_addr = req.wr && (req.addr == ssn_pkg::OFS_NVM_ADDR);
    assign wr_data = req.wr && (req.addr == ssn_pkg::OFS_NVM_DATA);

    // ----------------------------------------------------------------------
    // config and address registers
    // ----------------------------------------------------------------------
    logic [15:0] weak_cfg_q;
    logic [15:0] weak_cfg_d;
    logic [15:0] nvm_addr_q;
    logic [15:0] nvm_addr_d;

    // unused top config bits are masked so they always read back zero
    always_comb begin
        weak_cfg_d = weak_cfg_q;
        nvm_addr_d = nvm_addr_q;
        if (wr_cfg) begin
            weak_cfg_d = req.wdata & ssn_pkg::WEAK_CFG_MASK;
        end
        if (wr_addr) begin
            nvm_addr_d = req.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            weak_cfg_q <= ssn_pkg::WEAK_CFG_RST;
            nvm_addr_q <= ssn_pkg::NVM_ADDR_RST;
        end else begin
            weak_cfg_q <= weak_cfg_d;
            nvm_addr_q <= nvm_addr_d;
        end
    end

    // ----------------------------------------------------------------------
    // ready flag
    // ----------------------------------------------------------------------
    logic ready_q;
    logic ready_d;

    // results are in place when done fires, so ready follows them
    always_comb begin
        ready_d = ready_q;
        if (meas_start) begin
            ready_d = 1'b0;
        end else if (meas_done) begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    // ----------------------------------------------------------------------
    // weak-field flag
    // ----------------------------------------------------------------------
    logic weak_field_flag_q;
    logic weak_field_flag_d;
    logic [15:0] weak_field_threshold;
    logic [16:0] thr_full;
    logic [16:0] clear_lvl;
    logic [2:0] hyst;

    // threshold and hysteresis from config; the band shrinks by halves
    assign weak_field_threshold = {8'h00, weak_cfg_q[ssn_pkg::THR_LSB +: ssn_pkg::THR_W]};
    assign thr_full = {1'b0, weak_field_threshold} << ssn_pkg::THR_SCALE_SHIFT;
    assign hyst = weak_cfg_q[ssn_pkg::HYST_LSB +: ssn_pkg::HYST_W];
    assign clear_lvl = thr_full + (thr_full >> hyst);

    // only a finished measurement moves the flag; inside the band it holds
    always_comb begin
        weak_field_flag_d = weak_field_flag_q;
        if (meas_done) begin
            if ({1'b0, magnitude} < thr_full) begin
                weak_field_flag_d = 1'b1;
            end else if ({1'b0, magnitude} > clear_lvl) begin
                weak_field_flag_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            weak_field_flag_q <= 1'b0;
        end else begin
            weak_field_flag_q <= weak_field_flag_d;
        end
    end

    // ----------------------------------------------------------------------
    // non-volatile memory and write timer
    // ----------------------------------------------------------------------
    // small array stands in for the cell; only low address bits decode
    logic [15:0] nvm_mem [ssn_pkg::NVM_DEPTH];
    ssn_pkg::ssn_nvm_state_t nvm_st_q;
    ssn_pkg::ssn_nvm_state_t nvm_st_d;
    logic [31:0] wr_cnt_q;
    logic [31:0] wr_cnt_d;
    logic nvm_we;
    logic [ssn_pkg::NVM_AW-1:0] nvm_idx;
    logic [15:0] nvm_rword;

    assign nvm_idx = nvm_addr_q[ssn_pkg::NVM_AW-1:0];
    assign nvm_rword = nvm_mem[nvm_idx];
    // a write during programming is dropped: the host must wait for done
    assign nvm_we = wr_data && (nvm_st_q == ssn_pkg::SSN_IDLE);

    // ----------------------------------------------------------------------
    // write timer
    // ----------------------------------------------------------------------
    // one counter for the whole program time; 32 bits cover the 20 ms default
    always_comb begin
        nvm_st_d = nvm_st_q;
        wr_cnt_d = wr_cnt_q;
        case (nvm_st_q)
            ssn_pkg::SSN_IDLE: begin
                if (nvm_we) begin
                    nvm_st_d = ssn_pkg::SSN_PROG;
                    wr_cnt_d = 32'(WRITE_CYC - 1);
                end
            end
            ssn_pkg::SSN_PROG: begin
                if (wr_cnt_q == 32'h00000000) begin
                    nvm_st_d = ssn_pkg::SSN_IDLE;
                end else begin
                    wr_cnt_d = wr_cnt_q - 32'h00000001;
                end
            end
            default: begin
                nvm_st_d = ssn_pkg::SSN_IDLE;
                wr_cnt_d = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nvm_st_q <= ssn_pkg::SSN_IDLE;
            wr_cnt_q <= 32'h00000000;
        end else begin
            nvm_st_q <= nvm_st_d;
            wr_cnt_q <= wr_cnt_d;
        end
    end

    // memory array has no reset by design
    always_ff @(posedge sys_clk) begin
        if (nvm_we) begin
            nvm_mem[nvm_idx] <= req.wdata;
        end
    end

    // ----------------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------------
    logic [15:0] status;
    logic compute_fault;
    logic nvm_write_done;

    assign compute_fault = flags.converter_range_warning | flags.converter_histogram_warning
        | flags.scale_overflow | flags.temp_gain_overflow;
    assign nvm_write_done = (nvm_st_q == ssn_pkg::SSN_IDLE);

    always_comb begin
        status = ssn_pkg::ZERO16;
        status[ssn_pkg::BIT_READY] = ready_q;
        status[ssn_pkg::BIT_WEAK] = weak_field_flag_q;
        status[ssn_pkg::BIT_ANGLE_OVF] = flags.angle_fix_overflow;
        status[ssn_pkg::BIT_SCALE_OVF] = flags.scale_overflow;
        status[ssn_pkg::BIT_TGAIN_OVF] = flags.temp_gain_overflow;
        status[ssn_pkg::BIT_RANGE_WARN] = flags.converter_range_warning;
        status[ssn_pkg::BIT_HIST_WARN] = flags.converter_histogram_warning;
        status[ssn_pkg::BIT_FAULT] = compute_fault;
        status[ssn_pkg::BIT_ORIENT] = flags.field_orientation;
        status[ssn_pkg::BIT_WR_DONE] = nvm_write_done;
    end

    // ----------------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------------
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic rvalid_d;
    logic rvalid_q;

    // rdata keeps the last answer so a slow host may still pick it up
    // unmapped offsets answer zero rather than the previous word
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = req.rd;
        if (req.rd) begin
            case (req.addr)
                ssn_pkg::OFS_WEAK_CFG: begin
                    rdata_d = weak_cfg_q;
                end
                ssn_pkg::OFS_NVM_ADDR: begin
                    rdata_d = nvm_addr_q;
                end
                ssn_pkg::OFS_NVM_DATA: begin
                    rdata_d = nvm_rword;
                end
                ssn_pkg::OFS_STATUS: begin
                    rdata_d = status;
                end
                ssn_pkg::OFS_CHECKSUM: begin
                    rdata_d = checksum;
                end
                default: begin
                    rdata_d = ssn_pkg::ZERO16;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= ssn_pkg::ZERO16;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign ready_pin = ready_q;
endmodule : ssn_regs

// File: verif/ssn_regs_chk.sv
/*
 * ssn_regs_chk: port-level assertions for the sensor status register bank.
 * assumes: bound to ssn_regs; no measurement pulse during a status read.
 */
`timescale 1ns/100ps
module ssn_regs_chk #(
    parameter int WRITE_CYC = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register access
    input wire ssn_pkg::ssn_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    // measurement side and pin
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic [15:0] magnitude,
    input wire ssn_pkg::ssn_flags_t flags,
    input wire logic [15:0] checksum,
    input wire logic ready_pin
);
    // ----
    // helpers
    // ----
    logic [5:0] fl_q;
    logic [15:0] ck_q;
    always_ff @(posedge sys_clk) begin
        fl_q <= flags;
        ck_q <= checksum;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence stat_rd;
        req.rd && req.addr == ssn_pkg::OFS_STATUS && !meas_start && !meas_done;
    endsequence
    sequence sum_rd;
        req.rd && req.addr == ssn_pkg::OFS_CHECKSUM;
    endsequence
    rd_answer_a: assert property (req.rd |=> rvalid) else $error("read not answered");
    rv_pulse_a: assert property (!req.rd |=> !rvalid) else $error("read answer held");
    ready_clr_a: assert property (meas_start |=> !ready_pin) else $error("ready kept");
    ready_set_a: assert property (meas_done && !meas_start |=> ready_pin)
        else $error("ready not set");
    ready_hold_a: assert property (!meas_start && !meas_done |=> $stable(ready_pin))
        else $error("ready moved");
    stat_ready_a: assert property (stat_rd |=> rdata[15] == ready_pin)
        else $error("status ready differs from pin");
    resv_zero_a: assert property (stat_rd |=> rdata[7:2] == 6'h00)
        else $error("reserved bits set");
    flag_map_a: assert property (stat_rd |=> rdata[13:9] == fl_q[5:1])
        else $error("flag bits wrong");
    fault_or_a: assert property (stat_rd |=> rdata[8] == (|fl_q[4:1]))
        else $error("fault bit wrong");
    sum_read_a: assert property (sum_rd |=> rdata == ck_q) else $error("checksum wrong");
endmodule : ssn_regs_chk

// File: verif/ssn_host.sv
/*
 * ssn_host: host side of the word access port, with read and write tasks.
 * assumes: strobes are taken on the rising edge of sys_clk.
 */
`timescale 1ns/100ps
module ssn_host (
    // clock
    input wire logic sys_clk,
    // access port
    output ssn_pkg::ssn_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    // released lines show the inverse, so a stale address never looks live
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 16'hFFFF, wdata: 16'hFFFF};
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        int n;
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
        n = 0;
        do @(posedge sys_clk); while (rvalid !== 1'b1 && ++n < 4);
        v = rdata;
    endtask : rd
endmodule : ssn_host

// File: verif/tb_ssn_regs.sv
/*
 * tb_ssn_regs: register-level tests of ssn_regs driven through ssn_host.
 * assumes: 100 MHz clock; memory write time shortened to WCYC cycles.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_ssn_regs;
    localparam int WCYC = 20;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic meas_start = 1'b0;
    logic meas_done = 1'b0;
    logic [15:0] magnitude = 16'h0000;
    ssn_pkg::ssn_flags_t flags = '0;
    logic [15:0] checksum = 16'h3C5A;
    ssn_pkg::ssn_req_t req;
    logic [15:0] rdata, d;
    logic rvalid, ready_pin;
    logic [5:0] f;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    ssn_regs #(.WRITE_CYC(WCYC)) uut (.sys_clk(sys_clk), .rstn(rstn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .meas_start(meas_start), .meas_done(meas_done),
        .magnitude(magnitude), .flags(flags), .checksum(checksum), .ready_pin(ready_pin));
    ssn_host host (.sys_clk(sys_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic rchk(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
        host.rd(a, d);
        `CHK("register read", e, d & m)
    endtask : rchk
    task automatic meas(input logic [15:0] m);
        @(posedge sys_clk);
        meas_start <= 1'b1;
        @(posedge sys_clk);
        meas_start <= 1'b0;
        meas_done <= 1'b1;
        magnitude <= m;
        @(posedge sys_clk);
        meas_done <= 1'b0;
        `CHK("ready low", 1'b0, ready_pin)
        @(posedge sys_clk);
        `CHK("ready high", 1'b1, ready_pin)
    endtask : meas
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        logic [15:0] mg [8];
        logic [7:0] wk;
        logic [15:0] ex;
        mg = '{16'h00C0, 16'h00BF, 16'h0120, 16'h0121, 16'h0100, 16'h00FF, 16'h0140, 16'h0141};
        wk = 8'h66;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        `CHK("ready after reset", 1'b0, ready_pin)
        rchk(ssn_pkg::OFS_STATUS, 16'hBFFF, 16'h0001);
        rchk(ssn_pkg::OFS_WEAK_CFG, 16'hFFFF, 16'h0103);
        rchk(16'h0200, 16'hFFFF, 16'h0000);
        // ----
        // weak field: threshold V*64, clear above threshold plus hysteresis
        // ----
        for (int i = 0; i < 8; i++) begin
            if (i == 4) host.wr(ssn_pkg::OFS_WEAK_CFG, 16'h0204);
            meas(mg[i]);
            rchk(ssn_pkg::OFS_STATUS, 16'hC000, {1'b1, wk[i], 14'h0});
        end
        for (int i = 0; i < 6; i++) begin
            f = 6'h01 << i;
            @(posedge sys_clk);
            flags <= f;
            ex = {2'b10, f[5:1], |f[4:1], 6'h00, f[0], 1'b1};
            rchk(ssn_pkg::OFS_STATUS, 16'hFFFF, ex);
        end
        host.wr(ssn_pkg::OFS_STATUS, 16'h0000);
        host.wr(ssn_pkg::OFS_CHECKSUM, 16'h0000);
        rchk(ssn_pkg::OFS_CHECKSUM, 16'hFFFF, 16'h3C5A);
        checksum <= 16'hC3A5;
        rchk(ssn_pkg::OFS_CHECKSUM, 16'hFFFF, 16'hC3A5);
        rchk(ssn_pkg::OFS_STATUS, 16'hFFFF, 16'hA001);
        // ----
        // memory window: second write while busy is dropped
        // ----
        host.wr(ssn_pkg::OFS_NVM_ADDR, 16'h0005);
        host.wr(ssn_pkg::OFS_NVM_DATA, 16'hA5C3);
        rchk(ssn_pkg::OFS_STATUS, 16'h0001, 16'h0000);
        host.wr(ssn_pkg::OFS_NVM_DATA, 16'h1234);
        repeat (10) @(posedge sys_clk);
        rchk(ssn_pkg::OFS_STATUS, 16'h0001, 16'h0000);
        n = 0;
        do host.rd(ssn_pkg::OFS_STATUS, d); while (d[0] !== 1'b1 && ++n < 20);
        `CHK("write done", 1'b1, d[0])
        rchk(ssn_pkg::OFS_NVM_DATA, 16'hFFFF, 16'hA5C3);
        rchk(ssn_pkg::OFS_NVM_ADDR, 16'hFFFF, 16'h0005);
        host.wr(ssn_pkg::OFS_NVM_ADDR, 16'h0006);
        host.wr(ssn_pkg::OFS_NVM_DATA, 16'h5A3C);
        repeat (WCYC - 2) @(posedge sys_clk);
        rchk(ssn_pkg::OFS_STATUS, 16'h0001, 16'h0000);
        rchk(ssn_pkg::OFS_STATUS, 16'h0001, 16'h0001);
        rchk(ssn_pkg::OFS_NVM_DATA, 16'hFFFF, 16'h5A3C);
        host.wr(ssn_pkg::OFS_NVM_ADDR, 16'h0005);
        rchk(ssn_pkg::OFS_NVM_DATA, 16'hFFFF, 16'hA5C3);
        tally_and_finish();
    end
endmodule : tb_ssn_regs
bind ssn_regs ssn_regs_chk #(.WRITE_CYC(WRITE_CYC)) chk (.sys_clk(sys_clk), .rstn(rstn),
    .req(req), .rdata(rdata), .rvalid(rvalid), .meas_start(meas_start),
    .meas_done(meas_done), .magnitude(magnitude), .flags(flags), .checksum(checksum),
    .ready_pin(ready_pin));
